// File: rtl/ee_defines.svh
// timing counts and field sizes of the serial eeprom host
// assumes a 200 MHz system clock
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
`define EE_CLK_MHZ 200
`define EE_T_STROBE_NS 50
`define EE_T_GAP_NS 20
`define EE_STROBE_CYC ((`EE_T_STROBE_NS * `EE_CLK_MHZ + 999) / 1000)
`define EE_GAP_CYC ((`EE_T_GAP_NS * `EE_CLK_MHZ + 999) / 1000)
`define EE_ADDR_BITS 16
`define EE_IGNORED_BITS 7
`define EE_BYTE_BITS 8
`define EE_PAGE_BYTES 8
`define EE_FIFO_DEPTH 16
`endif

// File: rtl/ee_pkg.sv
// types shared by the serial eeprom host
// no assumptions beyond a single clock domain
package ee_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_STATUS} op_e;
  typedef enum logic [3:0] {
    S_IDLE, S_RST_R1, S_RST_W0, S_RST_R2, S_ADDR, S_LOAD, S_DATA_W,
    S_DATA_R, S_END_R, S_CMD_W1, S_CMD_R, S_POLL, S_FINISH
  } seq_e;
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} cyc_e;
endpackage

// File: rtl/bit_if.sv
// one-bit bus cycle request between sequencer and pin engine
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface bit_if;
  logic req;
  logic wr;
  logic wbit;
  logic done;
  logic rbit;
  modport seq (output req, wr, wbit, input done, rbit);
  modport eng (input req, wr, wbit, output done, rbit);
endinterface
`default_nettype wire

// File: rtl/sync_fifo.sv
// synchronous fifo, flop storage, registered in_ready
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;
  logic [CW-1:0]    next_count;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop)
      next_count = count + CW'(1);
    else if (pop && !push)
      next_count = count - CW'(1);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      count <= next_count;
      in_ready <= next_count != CW'(DEPTH);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// File: rtl/pin_engine.sv
// drives one strobed bus cycle on the eeprom pins per request
// assumes requests arrive only while idle
`timescale 1ns/1ps
`default_nettype none
`include "ee_defines.svh"
module pin_engine
  import ee_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // request side
  bit_if.eng        bus,
  // device pins
  output logic      ce_n,
  output logic      oe_n,
  output logic      we_n,
  output logic      io_out,
  output logic      io_oe,
  input  wire logic io_in
);
  cyc_e       state;
  logic [7:0] cnt;

  // =======================================
  // cycle sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= E_IDLE;
      cnt <= 8'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      io_out <= 1'b0;
      io_oe <= 1'b0;
      bus.done <= 1'b0;
      bus.rbit <= 1'b0;
    end else begin
      bus.done <= 1'b0;
      case (state)
        E_IDLE: begin
          if (bus.req) begin
            ce_n <= 1'b0;
            we_n <= ~bus.wr;
            oe_n <= bus.wr;
            io_out <= bus.wbit;
            io_oe <= bus.wr;
            cnt <= 8'(`EE_STROBE_CYC - 1);
            state <= E_LOW;
          end
        end
        E_LOW: begin
          if (cnt == 8'h00) begin
            bus.rbit <= io_in;
            // strobes rise together, data held past the edge
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            cnt <= 8'(`EE_GAP_CYC - 1);
            state <= E_HIGH;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        E_HIGH: begin
          if (cnt == 8'h00) begin
            io_oe <= 1'b0;
            bus.done <= 1'b1;
            state <= E_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/eeprom_host.sv
// host controller for a strobed single-line serial eeprom
// assumes the device is wired to ce_n/oe_n/we_n/io and wp_n
`timescale 1ns/1ps
`default_nettype none
`include "ee_defines.svh"
module eeprom_host
  import ee_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire op_e        cmd_op,
  input  wire logic [8:0] cmd_addr,
  input  wire logic [3:0] cmd_len,
  // write data
  input  wire logic       wd_valid,
  output logic            wd_ready,
  input  wire logic [7:0] wd_data,
  // read data and status
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nv_busy,
  // protection
  input  wire logic       write_allow,
  output logic            wp_n,
  // device pins
  output logic            ce_n,
  output logic            oe_n,
  output logic            we_n,
  output logic            io_out,
  output logic            io_oe,
  input  wire logic       io_in
);
  bit_if bus ();

  seq_e        state;
  op_e         op;
  logic [15:0] addr_sh;
  logic [7:0]  data_sh;
  logic [3:0]  bitcnt;
  logic [3:0]  bytes_left;
  logic        pend;
  logic        issue;
  logic        need;
  logic        cyc_wr;
  logic        cyc_bit;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_data;

  // whole bytes only; a write is capped at one page
  function automatic logic [3:0] eff_len(op_e o, logic [3:0] l);
    if (o == OP_WRITE && l > 4'(`EE_PAGE_BYTES))
      return 4'(`EE_PAGE_BYTES);
    return l;
  endfunction

  // =======================================
  // write data buffer
  sync_fifo #(
    .WIDTH (`EE_BYTE_BITS),
    .DEPTH (`EE_FIFO_DEPTH)
  ) wd_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   (wd_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign fifo_pop = state == S_LOAD && fifo_valid;

  // =======================================
  // pin cycles
  pin_engine eng (
    .clock  (clock),
    .rst    (rst),
    .bus    (bus),
    .ce_n   (ce_n),
    .oe_n   (oe_n),
    .we_n   (we_n),
    .io_out (io_out),
    .io_oe  (io_oe),
    .io_in  (io_in)
  );

  // =======================================
  // cycle kind per step
  always_comb begin
    need = 1'b1;
    cyc_wr = 1'b0;
    cyc_bit = 1'b0;
    case (state)
      S_RST_W0: cyc_wr = 1'b1;
      S_ADDR: begin
        cyc_wr = 1'b1;
        cyc_bit = addr_sh[15];
      end
      S_DATA_W: begin
        cyc_wr = 1'b1;
        cyc_bit = data_sh[7];
      end
      S_CMD_W1: begin
        cyc_wr = 1'b1;
        cyc_bit = 1'b1;
      end
      S_RST_R1, S_RST_R2, S_DATA_R, S_END_R, S_CMD_R, S_POLL: need = 1'b1;
      default: need = 1'b0;
    endcase
  end

  assign issue = need && !pend && !bus.done;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.wbit <= 1'b0;
    end else begin
      bus.req <= issue;
      if (issue) begin
        bus.wr <= cyc_wr;
        bus.wbit <= cyc_bit;
      end
      if (bus.done)
        pend <= 1'b0;
      else if (issue)
        pend <= 1'b1;
    end
  end

  // =======================================
  // sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      op <= OP_READ;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            op <= cmd_op;
            if (cmd_op == OP_STATUS)
              state <= S_POLL;
            else if (eff_len(cmd_op, cmd_len) == 4'h0)
              state <= S_FINISH;
            else
              state <= S_RST_R1;
          end
        end
        S_RST_R1: if (bus.done) state <= S_RST_W0;
        S_RST_W0: if (bus.done) state <= S_RST_R2;
        S_RST_R2: if (bus.done) state <= S_ADDR;
        S_ADDR: begin
          if (bus.done && bitcnt == 4'h0)
            state <= (op == OP_READ) ? S_DATA_R : S_LOAD;
        end
        S_LOAD: if (fifo_valid) state <= S_DATA_W;
        S_DATA_W: begin
          if (bus.done && bitcnt == 4'h0)
            state <= (bytes_left == 4'h1) ? S_END_R : S_LOAD;
        end
        S_DATA_R: begin
          if (bus.done && bitcnt == 4'h0 && bytes_left == 4'h1)
            state <= S_FINISH;
        end
        S_END_R: if (bus.done) state <= S_CMD_W1;
        S_CMD_W1: if (bus.done) state <= S_CMD_R;
        S_CMD_R: if (bus.done) state <= S_POLL;
        S_POLL: begin
          if (bus.done && (bus.rbit || op == OP_STATUS))
            state <= S_FINISH;
        end
        S_FINISH: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // =======================================
  // address, data and counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_sh <= 16'h0000;
      data_sh <= 8'h00;
      bitcnt <= 4'h0;
      bytes_left <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            // upper bits are don't care to the device
            addr_sh <= {7'h00, cmd_addr};
            bytes_left <= eff_len(cmd_op, cmd_len);
          end
        end
        S_RST_R2: if (bus.done) bitcnt <= 4'(`EE_ADDR_BITS - 1);
        S_ADDR: begin
          if (bus.done) begin
            addr_sh <= {addr_sh[14:0], 1'b0};
            bitcnt <= (bitcnt == 4'h0) ? 4'(`EE_BYTE_BITS - 1) : bitcnt - 4'h1;
          end
        end
        S_LOAD: begin
          if (fifo_valid) begin
            data_sh <= fifo_data;
            bitcnt <= 4'(`EE_BYTE_BITS - 1);
          end
        end
        S_DATA_W: begin
          if (bus.done) begin
            data_sh <= {data_sh[6:0], 1'b0};
            bitcnt <= bitcnt - 4'h1;
            if (bitcnt == 4'h0)
              bytes_left <= bytes_left - 4'h1;
          end
        end
        S_DATA_R: begin
          if (bus.done) begin
            data_sh <= {data_sh[6:0], bus.rbit};
            bitcnt <= (bitcnt == 4'h0) ? 4'(`EE_BYTE_BITS - 1) : bitcnt - 4'h1;
            if (bitcnt == 4'h0)
              bytes_left <= bytes_left - 4'h1;
          end
        end
        default: bitcnt <= bitcnt;
      endcase
    end
  end

  // =======================================
  // user-facing outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nv_busy <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (state == S_IDLE && cmd_valid && cmd_ready)
        cmd_ready <= 1'b0;
      if (state == S_FINISH) begin
        cmd_ready <= 1'b1;
        done <= 1'b1;
      end
      if (state == S_DATA_R && bus.done && bitcnt == 4'h0) begin
        rd_data <= {data_sh[6:0], bus.rbit};
        rd_valid <= 1'b1;
      end
      if (state == S_POLL && bus.done)
        nv_busy <= ~bus.rbit;
      else if (state == S_CMD_R && bus.done)
        nv_busy <= 1'b1;
    end
  end

  // protect pin follows the user's permission
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      wp_n <= 1'b0;
    else
      wp_n <= write_allow;
  end
endmodule
`default_nettype wire

// File: tb/eeprom_host_props.sv
// checker of the eeprom host pin and command timing
// assumes binding to eeprom_host, one clock
`timescale 1ns/1ps
`default_nettype none
`include "ee_defines.svh"
module eeprom_host_props
  import ee_pkg::*;
(
  // clock, reset, command
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire op_e  cmd_op,
  input wire logic done,
  // pins
  input wire logic write_allow,
  input wire logic wp_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic io_out,
  input wire logic io_oe
);
  localparam int STROBE = `EE_STROBE_CYC;
  logic [7:0] low_cnt;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  // =====
  // clocks spent with chip select low
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      low_cnt <= 8'h00;
    else
      low_cnt <= ce_n ? 8'h00 : low_cnt + 8'h01;
  end
  chk_we_oe_apart: assert property (we_n || oe_n)
    else $error("both strobes low");
  chk_no_drive_read: assert property (!oe_n |-> !io_oe)
    else $error("io driven in read");
  chk_strobe_select: assert property (ce_n |-> we_n && oe_n)
    else $error("strobe unselected");
  chk_data_steady: assert property (
    !we_n && !$past(we_n) |-> io_oe && $stable(io_out))
    else $error("data moved in strobe");
  chk_data_hold: assert property ($rose(we_n) |-> io_oe && $stable(io_out))
    else $error("data released early");
  chk_strobe_width: assert property ($rose(ce_n) |-> low_cnt == 8'(STROBE))
    else $error("strobe width");
  chk_gap_high: assert property ($rose(ce_n) |-> ce_n [*4])
    else $error("gap too short");
  chk_idle_deselect: assert property (cmd_ready |-> ce_n)
    else $error("selected while idle");
  chk_wp_follow: assert property (!$past(rst) |-> wp_n == $past(write_allow))
    else $error("protect not following");
  chk_status_done: assert property (
    cmd_valid && cmd_ready && cmd_op == OP_STATUS |-> ##[1:40] done)
    else $error("status not done");
endmodule
bind eeprom_host eeprom_host_props i_eeprom_host_props (
  .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .done(done), .write_allow(write_allow), .wp_n(wp_n),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// File: tb/ee_dev_model.sv
// behavioural strobed single-line serial eeprom
// assumes io is the resolved line level
`timescale 1ns/1ps
`default_nettype none
module ee_dev_model #(
  parameter int BUSY_NS = 3000
) (
  // host pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic wp_n,
  input wire logic io,
  // line drive
  output logic     d_oe,
  output logic     d_bit
);
  logic [7:0] mem [512];
  logic [7:0] pg [8];
  logic [7:0] sh;
  logic [7:0] mask;
  logic [8:0] ad;
  logic       wel = 1'b0;
  logic       busy = 1'b0;
  logic       lastr = 1'b0;
  logic       wcyc = 1'b0;
  logic       rcyc = 1'b0;
  int         mode = 0;
  int         n = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign d_oe = !ce_n && !oe_n;
  // =====
  // cycle start, read data out
  always @(negedge ce_n or negedge we_n or negedge oe_n) begin
    wcyc = wcyc | (!ce_n && !we_n);
    rcyc = rcyc | (!ce_n && !oe_n);
    if (!ce_n && !oe_n)
      d_bit = busy ? 1'b0 : mode == 2 ? mem[ad][3'h7 - 3'(n)] : 1'b1;
  end
  // =====
  // first rising strobe ends the cycle
  always @(posedge ce_n or posedge we_n or posedge oe_n) begin
    if (wcyc) begin
      wcyc = 1'b0;
      wr_bit(io);
      lastr = 1'b0;
    end
    if (rcyc) begin
      rcyc = 1'b0;
      rd_end();
      lastr = 1'b1;
    end
  end
  task automatic wr_bit(input logic b);
    logic [2:0] k;
    if (lastr && !b && !(mode == 1 && n == 0)) begin
      if (!busy) begin
        mode = 1;
        n = 0;
        mask = 8'h00;
        wel = wp_n;
      end
    end else if (mode == 1) begin
      ad = {ad[7:0], b};
      n++;
      if (n == 16) begin
        mode = 2;
        n = 0;
      end
    end else if (mode == 2 || mode == 3) begin
      sh = {sh[6:0], b};
      mode = 3;
      n++;
      k = ad[2:0] + 3'(n / 8 - 1);
      if (n % 8 == 0) begin
        pg[k] = sh;
        mask[k] = 1'b1;
      end
    end else
      mode = (mode == 4 && b) ? 5 : 0;
  endtask
  task automatic rd_end();
    if (mode == 2) begin
      n++;
      if (n == 8) begin
        n = 0;
        ad++;
      end
    end else if (mode == 3)
      mode = (n % 8 == 0) ? 4 : 0;
    else if (mode == 5) begin
      if (wel && wp_n) begin
        foreach (pg[i])
          if (mask[i])
            mem[{ad[8:3], 3'(i)}] = pg[i];
        busy = 1'b1;
      end
      mode = 0;
    end else if (mode == 1 && n > 0)
      mode = 0;
  endtask
  always @(posedge busy) begin
    #(BUSY_NS);
    busy = 1'b0;
    wel = 1'b0;
  end
  always @(negedge wp_n) wel = 1'b0;
endmodule
`default_nettype wire

// File: tb/tb.sv
// bench of the serial eeprom host against the device model
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module tb
  import ee_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  op_e        cmd_op = OP_STATUS;
  logic [8:0] cmd_addr = 9'h000;
  logic [3:0] cmd_len = 4'h0;
  logic       wd_valid = 1'b0;
  logic [7:0] wd_data = 8'h00;
  logic       write_allow = 1'b1;
  logic       flt = 1'b0;
  logic       cmd_ready, wd_ready, rd_valid, done, nv_busy, wp_n;
  logic       ce_n, oe_n, we_n, io_out, io_oe, d_oe, d_bit;
  logic [7:0] rd_data;
  logic [7:0] exp_mem [512];
  logic [7:0] got [$];
  int         bad_count = 0;
  int         checks = 0;
  int         busy_cyc = 0;
  wire logic  io_in = io_oe ? io_out : d_oe ? d_bit : flt;
  always #2.5 clock = ~clock;
  always @(posedge clock) flt <= ~flt;
  // slot of the i-th byte of a page load that starts at a
  function automatic logic [8:0] page_slot(input logic [8:0] a, input int i);
    return {a[8:3], 3'(a[2:0] + 3'(i))};
  endfunction
  eeprom_host i_eeprom_host (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wd_valid(wd_valid),
    .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .nv_busy(nv_busy), .write_allow(write_allow), .wp_n(wp_n),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in));
  ee_dev_model i_ee_dev_model (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wp_n(wp_n), .io(io_in),
    .d_oe(d_oe), .d_bit(d_bit));
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
      fail($sformatf("byte %h not %h", g, e));
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    checks++;
    if (g !== e)
      fail("flag wrong");
  endtask
  task automatic push(input logic [7:0] q[$]);
    int t;
    foreach (q[i]) begin
      wd_valid <= 1'b1;
      wd_data <= q[i];
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (wd_ready !== 1'b1 && t < 100);
      if (t == 100) begin
        fail("fifo stuck");
        close_out();
      end
    end
    wd_valid <= 1'b0;
  endtask
  task automatic run(input op_e op, input logic [8:0] a, input logic [3:0] l);
    int t;
    got = {};
    busy_cyc = 0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= l;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (t = 0; t < 30000 && done !== 1'b1; t++) begin
      @(posedge clock);
      if (rd_valid === 1'b1)
        got.push_back(rd_data);
      if (nv_busy === 1'b1)
        busy_cyc++;
    end
    if (t == 30000) begin
      fail("no done");
      close_out();
    end
  endtask
  task automatic wr(input logic [8:0] a, input int l, input logic allow);
    logic [7:0] q[$];
    write_allow <= allow;
    for (int i = 0; i < l; i++) begin
      q.push_back(8'($urandom));
      if (allow)
        exp_mem[page_slot(a, i)] = q[i];
    end
    push(q);
    // a full page asks for more; only one page may go out
    run(OP_WRITE, a, (l == 8) ? 4'hc : 4'(l));
    cmp_flag(nv_busy, 1'b0);
    // a real nonvolatile write keeps busy up for hundreds of clocks
    cmp_flag(busy_cyc > 100, allow);
  endtask
  task automatic rd(input logic [8:0] a, input int l);
    run(OP_READ, a, 4'(l));
    cmp_flag(got.size() == l, 1'b1);
    foreach (got[i])
      cmp_byte(got[i], exp_mem[9'(a + 9'(i))]);
  endtask
  initial begin
    logic [8:0] a;
    logic [7:0] q1 [$];
    int l;
    foreach (exp_mem[i]) exp_mem[i] = 8'hff;
    void'($urandom(32'h24284319));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp_flag(cmd_ready, 1'b1);
    run(OP_STATUS, 9'h000, 4'h0);
    cmp_flag(nv_busy, 1'b0);
    wr(9'h0c6, 4, 1'b1);
    rd(9'h0c0, 8);
    wr(9'h1f8, 8, 1'b1);
    rd(9'h1fe, 4);
    rd(9'h040, 0);
    exp_mem[9'h088] = 8'h5a;
    exp_mem[9'h089] = 8'ha5;
    q1 = {8'h5a};
    push(q1);
    q1 = {8'ha5};
    fork
      run(OP_WRITE, 9'h088, 4'h2);
      begin
        // page load stalls on the empty fifo; device stays deselected
        repeat (600) @(posedge clock);
        repeat (100) begin
          @(posedge clock);
          cmp_flag(ce_n, 1'b1);
        end
        push(q1);
      end
    join
    rd(9'h088, 2);
    wr(9'h040, 5, 1'b0);
    rd(9'h040, 5);
    repeat (4) begin
      a = 9'($urandom);
      l = 1 + $urandom % 8;
      wr(a, l, 1'b1);
      rd(a, l);
    end
    close_out();
  end
endmodule
`default_nettype wire
